//--- verilog/hcsd_pkg.sv
package hcsd_pkg;

  // ----------------------------------------------------------------
  // Register map and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h1C;
  localparam logic [7:0] STATUS_RST = 8'h10;
  localparam int UV_BIT = 0;
  localparam int NVM_BIT = 1;
  localparam int PIN_FLT_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int PIN_LVL_BIT = 4;

  // ----------------------------------------------------------------
  // Mode codes and field limits
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_TRIG = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [2:0] AVG_MAX = 3'h5;
  localparam logic [2:0] BAND_MIN_CODE = 3'h2;
  localparam logic [1:0] PIN_FLT_CNT = 2'h3;
  localparam logic signed [16:0] TEMP_REF = 17'sh00000;
  localparam int TC_SHIFT = 16;
  localparam logic [8:0] TC_COEF_1 = 9'h020;
  localparam logic [8:0] TC_COEF_2 = 9'h030;
  localparam logic [8:0] TC_COEF_3 = 9'h040;

  // ----------------------------------------------------------------
  // Timing, 20 ns clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPIN_TIME_NS = 10000;
  localparam int ADC_TIME_NS = 10000;
  localparam int IRQ_TIME_NS = 10000;
  localparam logic [11:0] SPIN_CYC = 12'((SPIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ADC_CYC = 12'((ADC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] IRQ_CYC = 12'((IRQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CH_TEMP, CH_X, CH_Y, CH_Z} hcsd_ch_t;
  typedef enum logic {ST_IDLE, ST_RUN} hcsd_state_t;
  typedef struct packed {
    logic [2:0] len;
    hcsd_ch_t [3:0] ch;
  } hcsd_seq_t;

  // Slot list: temperature always first, then the enabled axes
  function automatic hcsd_seq_t seq_decode(input logic [3:0] code);
    logic [8:0] t;
    hcsd_seq_t s;
    case (code) // R10 R21
      4'h1: t = {3'h2, CH_X, CH_TEMP, CH_TEMP};
      4'h2: t = {3'h2, CH_Y, CH_TEMP, CH_TEMP};
      4'h3: t = {3'h3, CH_X, CH_Y, CH_TEMP};
      4'h4: t = {3'h2, CH_Z, CH_TEMP, CH_TEMP};
      4'h5: t = {3'h3, CH_Z, CH_X, CH_TEMP};
      4'h6: t = {3'h3, CH_Y, CH_Z, CH_TEMP};
      4'h7: t = {3'h4, CH_X, CH_Y, CH_Z};
      4'h8: t = {3'h4, CH_X, CH_Y, CH_X};
      4'h9: t = {3'h4, CH_Y, CH_X, CH_Y};
      4'hA: t = {3'h4, CH_Y, CH_Z, CH_Y};
      4'hB: t = {3'h4, CH_X, CH_Z, CH_X};
      default: t = {3'h1, CH_TEMP, CH_TEMP, CH_TEMP};
    endcase
    s.len = t[8:6];
    s.ch[0] = CH_TEMP;
    s.ch[1] = hcsd_ch_t'(t[5:4]);
    s.ch[2] = hcsd_ch_t'(t[3:2]);
    s.ch[3] = hcsd_ch_t'(t[1:0]);
    return s;
  endfunction

  // Drift slope per magnet class; zero code turns compensation off
  function automatic logic [8:0] tc_coef(input logic [1:0] code);
    case (code) // R15
      2'h1: return TC_COEF_1;
      2'h2: return TC_COEF_2;
      2'h3: return TC_COEF_3;
      default: return 9'h000;
    endcase
  endfunction

endpackage

//--- verilog/hcsd_result_mem.sv
`timescale 1ns/10ps

module hcsd_result_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // Clock
  input wire logic mclk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; read data is registered
  always_ff @(posedge mclk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule // hcsd_result_mem

//--- verilog/hcsd_seq.sv
`timescale 1ns/10ps

// Summary of operation
// [R1] Pin fault sets status bit 2; reset zero; cleared by writing one.
// [R2] Memory checksum fault sets status bit 1 until written with one.
// [R3] Undervoltage sets status bit 0 until written with one.
// [R4] Mode 10b runs conversion sequences back to back without trigger.
// [R5] Each sample is spun and integrated, then converted and stored.
// [R6] Spin stage starts the next sample while the converter is busy.
// [R7] Every sequence converts temperature before any magnetic axis.
// [R8] That temperature compensates the magnetic results of the sequence.
// [R9] Mode 00b starts one sequence per command or pin trigger.
// [R10] Code 1011b gives X, Z, X; a Y, Z, Y code also exists.
// [R11] Middle axis completes midway between the two outer completions.
// [R12] Limit check on chosen axes: above, below, leave or enter band.
// [R13] Interrupt repeats after every sequence while the condition holds.
// [R14] Band codes 010b..111b double the band width each step.
// [R15] Drift select 00b disables compensation; others apply a slope.
// [R16] Results are averaged up to 32 samples per axis.
// [R17] Oscillator fault sets status bit 3 until written with one.
// [R18] Status bit 4 reads back the interrupt pin level.
// [R19] Diagnostic summary is high while any fault flag is set.
// [R20] Writing zero keeps a flag; a new fault beats a clear.
// [R21] Only enabled axes convert; then restart or wait for trigger.

module hcsd_seq #(
  parameter logic [15:0] BAND_BASE_LSB = 16'h0010
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Configuration fields
  input wire logic [1:0] run_mode_i,
  input wire logic [3:0] axis_channel_select_i,
  input wire logic [2:0] conversion_averaging_i,
  input wire logic limit_direction_select_i,
  input wire logic [2:0] threshold_band_width_i,
  input wire logic [1:0] magnet_drift_comp_select_i,
  input wire logic [2:0] limit_axis_en_i,
  input wire logic [15:0] limit_level_i,
  input wire logic conv_trigger_i,
  // Fault events
  input wire logic uv_event_i,
  input wire logic nvm_crc_event_i,
  input wire logic osc_event_i,
  // Analog front end
  output logic spin_start_o,
  output logic [1:0] spin_ch_o,
  output logic adc_start_o,
  output logic [1:0] adc_ch_o,
  input wire logic [15:0] adc_data_i,
  // Interrupt pin, open drain
  input wire logic int_pin_i,
  output logic int_pin_o,
  output logic int_oe_o,
  // Status and results
  output logic diagnostic_summary_flag_o,
  output logic busy_o,
  input wire logic [1:0] res_sel_i,
  output logic [15:0] res_data_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hcsd_pkg::hcsd_state_t state;
    logic [3:0] flags;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [1:0] pin_chk;
    logic [11:0] irq_cnt;
    logic [7:0] rdata;
    hcsd_pkg::hcsd_seq_t seq;
    logic [2:0] avg;
    logic spin_busy;
    logic spin_fin;
    logic spin_go;
    logic [11:0] spin_cnt;
    logic [1:0] spin_slot;
    logic [4:0] spin_rep;
    hcsd_pkg::hcsd_ch_t spin_ch;
    logic held;
    logic held_first;
    logic held_last;
    logic held_end;
    hcsd_pkg::hcsd_ch_t held_ch;
    logic adc_busy;
    logic adc_go;
    logic adc_first;
    logic adc_last;
    logic adc_end;
    logic [11:0] adc_cnt;
    hcsd_pkg::hcsd_ch_t adc_ch;
    logic signed [20:0] acc;
    logic signed [15:0] temp;
    logic hit;
    logic res_we;
    hcsd_pkg::hcsd_ch_t res_ch;
    logic [15:0] res_val;
    logic [11:0] gap_cnt;
    logic [11:0] prev_gap;
    logic [1:0] gap_n;
  } hcsd_regs_t;

  hcsd_regs_t s;
  hcsd_regs_t next_s;

  logic [7:0] status;
  logic [3:0] clr;
  logic [3:0] ev;
  logic pin_fault;
  logic trig;
  logic [4:0] reps_m1;
  logic signed [20:0] acc_new;
  logic signed [15:0] avg_v;
  logic signed [16:0] dt;
  logic signed [41:0] prod;
  logic signed [15:0] comp;
  logic signed [17:0] half;
  logic signed [17:0] hi;
  logic signed [17:0] lo;
  logic signed [17:0] v18;
  logic signed [17:0] thr18;
  logic cond;
  logic [3:0] en4;
  logic adc_done;

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  // Status byte: reserved bits read zero, bit 4 is the live pin level
  assign status = {3'h0, s.pin_s2, s.flags}; // R18
  assign pin_fault = (s.pin_chk == hcsd_pkg::PIN_FLT_CNT); // R1
  assign ev = {osc_event_i, pin_fault, nvm_crc_event_i, uv_event_i};
  assign clr = (reg_wr_i && reg_addr_i == hcsd_pkg::STATUS_OFS) ? reg_wdata_i[3:0] : 4'h0;
  // Host trigger by command or by a falling edge it drives on the pin
  assign trig = conv_trigger_i | (s.pin_prev & ~s.pin_s2 & (s.irq_cnt == 12'h000)); // R9
  assign reps_m1 = 5'((6'h01 << s.avg) - 6'h01);
  assign adc_done = s.adc_busy && (s.adc_cnt == 12'h000);

  // Averaging: sum the repeats, then shift by the log2 count
  assign acc_new = s.adc_first ? {{5{adc_data_i[15]}}, adc_data_i}
                 : s.acc + {{5{adc_data_i[15]}}, adc_data_i}; // R16
  assign avg_v = 16'(acc_new >>> s.avg);
  // Drift slope applied against the temperature of this sequence
  assign dt = {s.temp[15], s.temp} - hcsd_pkg::TEMP_REF; // R8
  assign prod = avg_v * dt * $signed({1'b0, hcsd_pkg::tc_coef(magnet_drift_comp_select_i)});
  assign comp = avg_v + 16'(prod >>> hcsd_pkg::TC_SHIFT); // R15

  // Band centred on the limit; width doubles per code step
  assign half = 18'({2'h0, BAND_BASE_LSB} << (threshold_band_width_i - 3'h2)) >>> 1; // R14
  assign v18 = {{2{comp[15]}}, comp};
  assign thr18 = {{2{limit_level_i[15]}}, limit_level_i};
  assign hi = thr18 + half;
  assign lo = thr18 - half;
  assign en4 = {limit_axis_en_i, 1'b0};

  // Direction picks above/below, or with a band leave/enter
  always_comb
  begin
    if (threshold_band_width_i >= hcsd_pkg::BAND_MIN_CODE)
    begin
      cond = limit_direction_select_i ? (v18 >= lo && v18 <= hi)
           : (v18 > hi || v18 < lo); // R12
    end
    else
    begin
      cond = limit_direction_select_i ? (v18 < thr18) : (v18 > thr18); // R12
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.spin_go = 1'b0;
    next_s.adc_go = 1'b0;
    next_s.res_we = 1'b0;
    next_s.pin_s1 = int_pin_i;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_prev = s.pin_s2;
    next_s.gap_cnt = s.gap_cnt + 12'h001;
    // Set wins over a same-cycle clear; zero bits clear nothing
    next_s.flags = (s.flags & ~clr) | ev; // R1 R2 R3 R17 R20
    // Pin held low by us but read high means a broken pin
    if (s.irq_cnt != 12'h000 && s.pin_s2 && !pin_fault)
    begin
      next_s.pin_chk = s.pin_chk + 2'h1; // R1
    end
    else if (s.irq_cnt == 12'h000 || !s.pin_s2)
    begin
      next_s.pin_chk = 2'h0;
    end
    if (s.irq_cnt != 12'h000)
    begin
      next_s.irq_cnt = s.irq_cnt - 12'h001;
    end
    // Reads of unmapped offsets return zero
    if (reg_rd_i)
    begin
      next_s.rdata = (reg_addr_i == hcsd_pkg::STATUS_OFS) ? status : 8'h00;
    end
    // Sequence start
    unique case (s.state)
      hcsd_pkg::ST_IDLE:
      begin
        if (run_mode_i == hcsd_pkg::MODE_CONT
            || (run_mode_i == hcsd_pkg::MODE_TRIG && trig)) // R4 R9
        begin
          next_s.state = hcsd_pkg::ST_RUN;
          next_s.seq = hcsd_pkg::seq_decode(axis_channel_select_i); // R21
          next_s.avg = (conversion_averaging_i > hcsd_pkg::AVG_MAX) ? hcsd_pkg::AVG_MAX
                     : conversion_averaging_i; // R16
          next_s.spin_slot = 2'h0;
          next_s.spin_rep = 5'h00;
          next_s.spin_fin = 1'b0;
          next_s.hit = 1'b0;
          next_s.gap_n = 2'h0;
        end
      end
      hcsd_pkg::ST_RUN:
      begin
        // Spin stage; a free holding slot lets it run ahead of the ADC
        if (!s.spin_fin && !s.spin_busy && !s.held)
        begin
          next_s.spin_go = 1'b1; // R5 R6
          next_s.spin_busy = 1'b1;
          next_s.spin_cnt = hcsd_pkg::SPIN_CYC - 12'h001;
          next_s.spin_ch = s.seq.ch[s.spin_slot]; // R7
        end
        else if (s.spin_busy && s.spin_cnt != 12'h000)
        begin
          next_s.spin_cnt = s.spin_cnt - 12'h001;
        end
        else if (s.spin_busy)
        begin
          next_s.spin_busy = 1'b0;
          next_s.held = 1'b1;
          next_s.held_ch = s.spin_ch;
          next_s.held_first = (s.spin_rep == 5'h00);
          next_s.held_last = (s.spin_rep == reps_m1);
          next_s.held_end = (s.spin_rep == reps_m1)
                          && ({1'b0, s.spin_slot} == s.seq.len - 3'h1); // R21
          if (s.spin_rep == reps_m1)
          begin
            next_s.spin_rep = 5'h00;
            next_s.spin_slot = s.spin_slot + 2'h1;
            next_s.spin_fin = ({1'b0, s.spin_slot} == s.seq.len - 3'h1);
          end
          else
          begin
            next_s.spin_rep = s.spin_rep + 5'h01;
          end
        end
        // Converter stage takes the integrated sample
        if (!s.adc_busy && s.held)
        begin
          next_s.held = 1'b0; // R6
          next_s.adc_go = 1'b1;
          next_s.adc_busy = 1'b1;
          next_s.adc_cnt = hcsd_pkg::ADC_CYC - 12'h001;
          next_s.adc_ch = s.held_ch;
          next_s.adc_first = s.held_first;
          next_s.adc_last = s.held_last;
          next_s.adc_end = s.held_end;
        end
        else if (s.adc_busy && !adc_done)
        begin
          next_s.adc_cnt = s.adc_cnt - 12'h001;
        end
        else if (adc_done)
        begin
          next_s.adc_busy = 1'b0;
          next_s.acc = acc_new;
          // Fixed stage times keep completions evenly spaced
          next_s.gap_cnt = 12'h000; // R11
          next_s.prev_gap = s.gap_cnt;
          next_s.gap_n = (s.gap_n == 2'h2) ? 2'h2 : s.gap_n + 2'h1;
          if (s.adc_last && s.adc_ch == hcsd_pkg::CH_TEMP)
          begin
            next_s.temp = avg_v; // R7 R8
          end
          else if (s.adc_last)
          begin
            next_s.res_we = 1'b1; // R5
            next_s.res_ch = s.adc_ch;
            next_s.res_val = comp;
            next_s.hit = s.hit | (cond & en4[s.adc_ch]); // R12
          end
          if (s.adc_end)
          begin
            // Re-raise the interrupt each sequence the condition holds
            if (s.hit || (s.adc_last && cond && en4[s.adc_ch]))
            begin
              next_s.irq_cnt = hcsd_pkg::IRQ_CYC; // R13
            end
            next_s.state = hcsd_pkg::ST_IDLE; // R21
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Pin samplers start high, matching the idle pulled-up pin
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.pin_s1 <= hcsd_pkg::STATUS_RST[hcsd_pkg::PIN_LVL_BIT];
      s.pin_s2 <= hcsd_pkg::STATUS_RST[hcsd_pkg::PIN_LVL_BIT];
      s.pin_prev <= hcsd_pkg::STATUS_RST[hcsd_pkg::PIN_LVL_BIT];
    end
    else
    begin
      s <= next_s;
    end
  end

  hcsd_result_mem #(
    .WIDTH(16),
    .DEPTH(4),
    .AW(2)
  ) u_mem (
    .mclk_i(mclk_i),
    .we_i(s.res_we),
    .waddr_i(s.res_ch),
    .wdata_i(s.res_val),
    .raddr_i(res_sel_i),
    .rdata_o(res_data_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = s.rdata;
  assign spin_start_o = s.spin_go;
  assign spin_ch_o = s.spin_ch;
  assign adc_start_o = s.adc_go;
  assign adc_ch_o = s.adc_ch;
  assign int_pin_o = 1'b0;
  assign int_oe_o = (s.irq_cnt != 12'h000);
  assign diagnostic_summary_flag_o = |s.flags; // R19
  assign busy_o = (s.state == hcsd_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_uv_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    uv_event_i |=> s.flags[hcsd_pkg::UV_BIT])
    else $error("undervoltage flag not set");

  a_nvm_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
    nvm_crc_event_i |=> s.flags[hcsd_pkg::NVM_BIT])
    else $error("checksum flag not set");

  a_osc_flag_set: assert property (@(posedge mclk_i) disable iff (rst_i) // R17
    osc_event_i |=> s.flags[hcsd_pkg::OSC_BIT])
    else $error("oscillator flag not set");

  a_flag_clear: assert property (@(posedge mclk_i) disable iff (rst_i) // R20
    (clr[hcsd_pkg::UV_BIT] && !uv_event_i) |=> !s.flags[hcsd_pkg::UV_BIT])
    else $error("write one did not clear flag");

  a_flag_zero_keep: assert property (@(posedge mclk_i) disable iff (rst_i) // R20
    (reg_wr_i && reg_addr_i == hcsd_pkg::STATUS_OFS && reg_wdata_i[3:0] == 4'h0)
    |=> s.flags == ($past(s.flags) | $past(ev)))
    else $error("zero write changed a flag");

  a_pin_fault_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    pin_fault |=> s.flags[hcsd_pkg::PIN_FLT_BIT])
    else $error("pin fault flag not set");

  a_diag_summary: assert property (@(posedge mclk_i) disable iff (rst_i) // R19
    diagnostic_summary_flag_o == (s.flags != 4'h0))
    else $error("summary disagrees with flags");

  a_pin_readback: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
    reg_rd_i && reg_addr_i == hcsd_pkg::STATUS_OFS |=> reg_rdata_o[4] == $past(s.pin_s2))
    else $error("pin level bit wrong");

  a_cont_restart: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    (s.state == hcsd_pkg::ST_IDLE && run_mode_i == hcsd_pkg::MODE_CONT)
    |=> s.state == hcsd_pkg::ST_RUN ##1 spin_start_o)
    else $error("continuous mode did not restart");

  a_trig_wait: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    (s.state == hcsd_pkg::ST_IDLE && run_mode_i == hcsd_pkg::MODE_TRIG && !trig)
    |=> s.state == hcsd_pkg::ST_IDLE)
    else $error("sequence started without trigger");

  a_temp_first: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    (spin_start_o && $past(s.state, 2) == hcsd_pkg::ST_IDLE) |-> spin_ch_o == hcsd_pkg::CH_TEMP)
    else $error("first slot not temperature");

  a_spin_overlap: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
    (s.state == hcsd_pkg::ST_RUN && s.held && !s.adc_busy) |=> adc_start_o ##1 !s.held)
    else $error("converter did not take sample");

  a_even_spacing: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    (adc_done && s.gap_n == 2'h2) |-> s.gap_cnt == s.prev_gap)
    else $error("conversion completions unevenly spaced");

  a_irq_pulse: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
    (adc_done && s.adc_end && s.hit) |=> int_oe_o [*8])
    else $error("interrupt not raised on limit hit");

endmodule // hcsd_seq

//--- sim/hcsd_host_model.sv
`timescale 1ns/10ps

module hcsd_host_model (
  // Clock
  input wire logic mclk_i,
  // Converter side
  input wire logic adc_start_i,
  input wire logic [1:0] adc_ch_i,
  output logic [15:0] adc_data_o,
  // Pin side
  input wire logic int_oe_i,
  input wire logic pin_stuck_i,
  input wire logic pin_pull_i,
  output logic int_pin_o
);
  logic [11:0] cnt = 12'h000;
  logic [15:0] val = 16'h0000;

  // Pulled-up wire, pulled low by either side; a stuck-high fault beats both
  assign int_pin_o = pin_stuck_i | (~int_oe_i & ~pin_pull_i);

  // Sample valid only inside the conversion window, so a late grab shows
  always_ff @(posedge mclk_i)
  begin
    if (adc_start_i)
    begin
      cnt <= 12'h001;
      val <= {4'h4, 10'h000, adc_ch_i};
    end
    else if (cnt != 12'h000 && cnt <= hcsd_pkg::ADC_CYC)
      cnt <= cnt + 12'h001;
    else
      cnt <= 12'h000;
  end
  assign adc_data_o = (cnt != 12'h000) ? val : ~val;
endmodule // hcsd_host_model

//--- sim/testbench.sv
`timescale 1ns/10ps

module testbench;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rd;
  logic [1:0] run_mode_i = 2'h1, magnet_drift_comp_select_i = 2'h0, res_sel_i = 2'h1;
  logic [3:0] axis_channel_select_i = 4'hB;
  logic [2:0] conversion_averaging_i = 3'h0, threshold_band_width_i = 3'h0;
  logic [2:0] limit_axis_en_i = 3'h0;
  logic [15:0] limit_level_i = 16'h0000, adc_data_i, res_data_o;
  logic limit_direction_select_i = 1'b0, conv_trigger_i = 1'b0, pin_stuck = 1'b0;
  logic uv_event_i = 1'b0, nvm_crc_event_i = 1'b0, osc_event_i = 1'b0;
  logic spin_start_o, adc_start_o, int_pin_i, int_oe_o, diagnostic_summary_flag_o, busy_o;
  logic [1:0] spin_ch_o, adc_ch_o;
  logic pipe_seen = 1'b0, pin_pull = 1'b0;
  int errors = 0, checks_done = 0, cyc = 0, adc_age = 9999;
  int ts[4];

  hcsd_seq dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i,
    .reg_rdata_o, .run_mode_i, .axis_channel_select_i, .conversion_averaging_i,
    .limit_direction_select_i, .threshold_band_width_i, .magnet_drift_comp_select_i,
    .limit_axis_en_i, .limit_level_i, .conv_trigger_i, .uv_event_i, .nvm_crc_event_i,
    .osc_event_i, .spin_start_o, .spin_ch_o, .adc_start_o, .adc_ch_o, .adc_data_i,
    .int_pin_i, .int_pin_o(), .int_oe_o, .diagnostic_summary_flag_o, .busy_o,
    .res_sel_i, .res_data_o);

  hcsd_host_model host (.mclk_i, .adc_start_i(adc_start_o), .adc_ch_i(adc_ch_o),
    .adc_data_o(adc_data_i), .int_oe_i(int_oe_o), .pin_stuck_i(pin_stuck),
    .pin_pull_i(pin_pull), .int_pin_o(int_pin_i));

  // Clock, 20 ns period
  initial
  begin
    forever #10 mclk_i = ~mclk_i;
  end

  // Spin starting while the converter is busy proves the pipeline
  always @(negedge mclk_i)
  begin
    cyc++;
    adc_age = adc_start_o ? 0 : adc_age + 1;
    if (spin_start_o && adc_age < hcsd_pkg::ADC_CYC) pipe_seen = 1'b1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Data is registered at the taking edge; sample one edge later
  task automatic reg_rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    rd = reg_rdata_o;
  endtask

  // Collect channel codes of n conversions, oldest in the top bits
  task automatic grab(input int n, output logic [7:0] chs);
    int k;
    k = 0;
    chs = 8'h00;
    for (int i = 0; i < 4000 && k < n; i++)
    begin
      @(negedge mclk_i);
      if (adc_start_o)
      begin
        chs = {chs[5:0], adc_ch_o};
        ts[k] = cyc;
        k++;
      end
    end
  endtask

  task automatic final_report;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    reg_rd(8'h1C);
    chk(rd, hcsd_pkg::STATUS_RST);
    reg_rd(8'h1D);
    chk(rd, 8'h00);
    chk(diagnostic_summary_flag_o, 1'b0);
    chk(busy_o, 1'b0);
  endtask

  task automatic t_flags;
    @(posedge mclk_i);
    {uv_event_i, nvm_crc_event_i, osc_event_i} <= 3'h7;
    @(posedge mclk_i);
    {uv_event_i, nvm_crc_event_i, osc_event_i} <= 3'h0;
    reg_rd(8'h1C);
    chk(rd, 8'h1B);
    chk(diagnostic_summary_flag_o, 1'b1);
    reg_wr(8'h1C, 8'h00);
    reg_rd(8'h1C);
    chk(rd, 8'h1B);
    // Fault on bit 0 in the same cycle as a clear of bits 1 and 3: both must take effect
    @(posedge mclk_i);
    uv_event_i <= 1'b1;
    reg_addr_i <= 8'h1C;
    reg_wdata_i <= 8'h0A;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    uv_event_i <= 1'b0;
    reg_wr_i <= 1'b0;
    reg_rd(8'h1C);
    chk(rd, 8'h11);
    reg_wr(8'h1C, 8'h01);
    reg_rd(8'h1C);
    chk(rd, 8'h10);
    chk(diagnostic_summary_flag_o, 1'b0);
  endtask

  task automatic t_trig;
    logic [7:0] chs;
    int extra;
    extra = 0;
    @(posedge mclk_i);
    run_mode_i <= hcsd_pkg::MODE_TRIG;
    limit_axis_en_i <= 3'h1;
    repeat (3) @(posedge mclk_i);
    conv_trigger_i <= 1'b1;
    @(posedge mclk_i);
    conv_trigger_i <= 1'b0;
    grab(4, chs);
    chk(chs, 8'h1D);
    chk(pipe_seen, 1'b1);
    chk(16'(2 * ts[2]), 16'(ts[1] + ts[3]));
    // Field above the limit: the pin must be pulled after the sequence
    for (int i = 0; i < 1500 && int_oe_o !== 1'b1; i++)
    begin
      @(negedge mclk_i);
      if (adc_start_o) extra++;
    end
    chk(int_oe_o, 1'b1);
    chk(16'(extra), 16'h0000);
    @(posedge mclk_i);
    pin_stuck <= 1'b1;
    repeat (8) @(posedge mclk_i);
    reg_rd(8'h1C);
    chk(rd & 8'h04, 8'h04);
    // No drift class selected: the stored X sample is the raw code
    chk(res_data_o, 16'h4001);
    @(posedge mclk_i);
    pin_stuck <= 1'b0;
    // Let the synchronised pin settle so the fault no longer beats the clear
    repeat (4) @(posedge mclk_i);
    reg_wr(8'h1C, 8'h04);
    reg_rd(8'h1C);
    chk(rd & 8'h0F, 8'h00);
  endtask

  // Host pulls the idle pin low once: exactly one sequence follows
  task automatic t_pin_trig;
    logic [7:0] chs;
    for (int i = 0; i < 1000 && int_oe_o !== 1'b0; i++)
    begin
      @(negedge mclk_i);
    end
    chk(busy_o, 1'b0);
    repeat (3) @(posedge mclk_i);
    pin_pull <= 1'b1;
    repeat (4) @(posedge mclk_i);
    pin_pull <= 1'b0;
    grab(4, chs);
    chk(chs, 8'h1D);
  endtask

  task automatic t_cont;
    logic [7:0] chs;
    logic [15:0] exp_x;
    @(posedge mclk_i);
    axis_channel_select_i <= 4'h1;
    magnet_drift_comp_select_i <= 2'h1;
    res_sel_i <= 2'h1;
    run_mode_i <= hcsd_pkg::MODE_CONT;
    grab(3, chs);
    chk(chs, 8'h04);
    chk(busy_o, 1'b1);
    // Temperature code 4000h, zero reference, first magnet class slope
    exp_x = 16'(16'h4001 + ((longint'(16'h4001) * 16'h4000 * hcsd_pkg::TC_COEF_1)
      >> hcsd_pkg::TC_SHIFT));
    chk(res_data_o, exp_x);
    @(posedge mclk_i);
    run_mode_i <= 2'h1;
  endtask

  // Watchdog well above the few thousand cycles the scenarios need
  initial
  begin
    repeat (40000) @(posedge mclk_i);
    errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    t_reset();
    t_flags();
    t_trig();
    t_pin_trig();
    t_cont();
    final_report();
  end
endmodule // testbench
